// *** rtl/dpd_top.sv ***
/*
 * Slave diagnostic frame builder with APB registers and interrupt.
 * Assumes APB master on pclk; frame sink and master events on pclk.
 */
`timescale 1ns/1ps
`include "dpd_cfg.svh"
module dpd_top (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Bus side events
    input  wire logic        diag_req,
    input  wire logic        err_evt,
    input  wire logic [7:0]  err_code,
    // Frame byte stream
    output logic [7:0]       tx_byte,
    output logic             tx_valid,
    output logic             tx_last,
    input  wire logic        tx_ready,
    // Interrupt
    output logic             irq
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [23:0] stn_r;
    logic [7:0]  maddr_r;
    logic [15:0] ident_r;
    logic [7:0]  msg_r;
    logic [7:0]  diag_r;
    logic [39:0] udat_r;
    logic        uval_r;
    logic        pend_r;
    logic        start_r;
    logic [2:0]  ist_r;
    logic [2:0]  imsk_r;
    logic        trig_start;
    logic        trig_del;
    logic        acc;
    logic        wr;
    logic        rd_done;
    logic        hit;
    logic [31:0] rdat;
    logic [127:0] fw;
    logic [2:0]  ev;

    dpd_frame_if frm ();

    function automatic logic msg_ok(input logic [7:0] c);
        case (c)
            `DPD_MSG_PLEN, `DPD_MSG_CLEN, `DPD_MSG_CENT,
            `DPD_MSG_BUF, `DPD_MSG_NOCF, `DPD_MSG_CMP,
            `DPD_MSG_USER: msg_ok = 1'b1;
            default:       msg_ok = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // APB access, one wait state
    // ------------------------------------------------------------------
    assign acc     = psel && penable && !pready;
    assign wr      = psel && penable && pready && pwrite;
    assign rd_done = psel && penable && pready && !pwrite;

    always_comb begin
        hit  = 1'b1;
        rdat = 32'h0000_0000;
        if (paddr == `DPD_A_STN) begin
            rdat = {8'h00, stn_r};
        end else if (paddr == `DPD_A_MADDR) begin
            rdat = {24'h00_0000, maddr_r};
        end else if (paddr == `DPD_A_IDENT) begin
            rdat = {16'h0000, ident_r};
        end else if (paddr == `DPD_A_MSG) begin
            rdat = {24'h00_0000, msg_r};
        end else if (paddr == `DPD_A_DIAG) begin
            rdat = {24'h00_0000, diag_r};
        end else if (paddr == `DPD_A_UDAT0) begin
            rdat = udat_r[31:0];
        end else if (paddr == `DPD_A_UDAT1) begin
            rdat = {24'h00_0000, udat_r[39:32]};
        end else if (paddr == `DPD_A_ISTAT) begin
            rdat = {29'h0000_0000, ist_r};
        end else if (paddr == `DPD_A_IMASK) begin
            rdat = {29'h0000_0000, imsk_r};
        end else if (paddr == `DPD_A_STATUS) begin
            rdat = {29'h0000_0000, frm.busy, pend_r, uval_r};
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= acc;
            pslverr <= acc && !hit;
            if (acc && !pwrite) begin
                prdata <= rdat;
            end
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stn_r   <= 24'h00_0000;
            maddr_r <= 8'h00;
            ident_r <= 16'h0000;
            diag_r  <= 8'h00;
            udat_r  <= 40'h00_0000_0000;
        end else if (wr) begin
            if (paddr == `DPD_A_STN) begin
                stn_r <= pwdata[23:0] & `DPD_STN_WMASK;
            end else if (paddr == `DPD_A_MADDR) begin
                maddr_r <= pwdata[7:0];
            end else if (paddr == `DPD_A_IDENT) begin
                ident_r <= pwdata[15:0];
            end else if (paddr == `DPD_A_DIAG) begin
                diag_r <= pwdata[7:0];
            end else if (paddr == `DPD_A_UDAT0) begin
                udat_r[31:0] <= pwdata;
            end else if (paddr == `DPD_A_UDAT1) begin
                udat_r[39:32] <= pwdata[7:0];
            end
        end
    end

    // A listed error code wins over a same-cycle write: the fault is the news
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_r <= `DPD_MSG_RST;
        end else if (err_evt && msg_ok(err_code)) begin
            msg_r <= err_code;
        end else if (wr && paddr == `DPD_A_MSG && msg_ok(pwdata[7:0])) begin
            msg_r <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Report scheduling
    // ------------------------------------------------------------------
    dpd_trig u_trig (
        .pclk    (pclk),
        .presetn (presetn),
        .diag_st (diag_r),
        .start_p (trig_start),
        .del_p   (trig_del)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uval_r <= 1'b0;
        end else if (trig_start) begin
            uval_r <= 1'b1;
        end else if (trig_del) begin
            uval_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r  <= 1'b0;
            start_r <= 1'b0;
        end else begin
            // new request wins over the clear
            pend_r  <= diag_req || err_evt || trig_start
                       || (pend_r && !start_r);
            start_r <= pend_r && !start_r && !frm.busy;
        end
    end

    // ------------------------------------------------------------------
    // Frame assembly
    // ------------------------------------------------------------------
    always_comb begin
        fw = '0;
        fw[7:0]   = stn_r[7:0];
        fw[`DPD_EXT_BIT] = stn_r[`DPD_EXT_BIT] | uval_r;
        fw[15:8]  = stn_r[15:8] | `DPD_S1_FIX;
        fw[23:16] = stn_r[23:16];
        fw[31:24] = maddr_r;
        fw[39:32] = ident_r[15:8];
        fw[47:40] = ident_r[7:0];
        fw[55:48] = `DPD_DEV_LEN;
        fw[63:56] = msg_r;
        if (uval_r) begin
            fw[127:88] = udat_r;
        end
    end

    assign frm.frame = fw;
    assign frm.start = start_r;

    dpd_ser u_ser (
        .pclk     (pclk),
        .presetn  (presetn),
        .frm      (frm),
        .tx_byte  (tx_byte),
        .tx_valid (tx_valid),
        .tx_last  (tx_last),
        .tx_ready (tx_ready)
    );

    // ------------------------------------------------------------------
    // Interrupt: sticky status, cleared by reading it
    // ------------------------------------------------------------------
    always_comb begin
        ev = 3'h0;
        ev[`DPD_IRQ_SENT] = frm.done;
        ev[`DPD_IRQ_REQ]  = diag_req;
        ev[`DPD_IRQ_ERR]  = err_evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_r  <= 3'h0;
            imsk_r <= 3'h0;
            irq    <= 1'b0;
        end else begin
            // Clear only bits the read returned; later events survive
            if (rd_done && paddr == `DPD_A_ISTAT) begin
                ist_r <= (ist_r & ~prdata[2:0]) | ev;
            end else begin
                ist_r <= ist_r | ev;
            end
            if (wr && paddr == `DPD_A_IMASK) begin
                imsk_r <= pwdata[2:0];
            end
            irq <= |(ist_r & imsk_r);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_req;
        diag_req |=> pend_r;
    endproperty
    a_req: assert property (p_req)
        else $error("master request not queued");

    property p_serve;
        (pend_r && !frm.busy && !start_r) |=> start_r ##1 frm.busy;
    endproperty
    a_serve: assert property (p_serve)
        else $error("pending report not started");

    property p_s0;
        (fw[7:0] & `DPD_S0_FIXZ) == 8'h00;
    endproperty
    a_s0: assert property (p_s0)
        else $error("fixed zero bit set in status byte 0");

    property p_s1;
        fw[10] && !fw[15] && !fw[14];
    endproperty
    a_s1: assert property (p_s1)
        else $error("status byte 1 fixed bits wrong");

    property p_s2;
        fw[22:16] == 7'h00;
    endproperty
    a_s2: assert property (p_s2)
        else $error("reserved status byte 2 bits set");

    property p_madr;
        (wr && paddr == `DPD_A_MADDR) |=> fw[31:24] == $past(pwdata[7:0]);
    endproperty
    a_madr: assert property (p_madr)
        else $error("master address not in byte 3");

    property p_id;
        fw[39:32] == ident_r[15:8] && fw[47:40] == ident_r[7:0];
    endproperty
    a_id: assert property (p_id)
        else $error("ident bytes misplaced");

    property p_dev;
        fw[55:48] == `DPD_DEV_LEN && fw[87:64] == 24'h00_0000;
    endproperty
    a_dev: assert property (p_dev)
        else $error("byte 6 or reserved bytes wrong");

    property p_msg;
        msg_ok(fw[63:56]);
    endproperty
    a_msg: assert property (p_msg)
        else $error("byte 7 holds an unlisted code");

    property p_user;
        trig_start |=> uval_r && fw[127:88] == udat_r;
    endproperty
    a_user: assert property (p_user)
        else $error("user data not framed after start");
endmodule

// *** inc/dpd_cfg.svh ***
/*
 * Constants of the slave diagnostic frame builder: register offsets,
 * field masks, fixed frame bytes, message codes and reset values.
 * Assumes inclusion by bare name from every design file that needs it.
 */
// Function
// - Send diagnostics on master request and on own error, unprompted.
// - Frame is bytes 0..5 standard part, bytes 6..15 device part.
// - Bytes 11..15 carry CPU-written user data, forwarded to master.
// - Local CPU can start a report and edit the user data first.
// - Byte 6 length/code, byte 7 message code, bytes 8..10 reserved.
// - Status byte 0: bits 0,5,7 zero; bits 1,2,3,4,6 are flags.
// - Status byte 1: flags 0,1,3,4,5; bit 2 one; bits 6,7 zero.
// - Status byte 2: bit 7 overflow, bits 0..6 reserved.
// - Byte 3 holds address of the parametrizing master.
// - Byte 6 is length ten in bits 0..5, code 00 in bits 6..7.
// - Byte 7 holds one of codes 12h..17h or 40h.
// - A 0 to 1 change of diagnostic status bit 0 starts a report.
// - Diagnostic status value 0000 0011 causes no action.
`ifndef DPD_CFG_SVH
`define DPD_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DPD_A_STN      8'h00
`define DPD_A_MADDR    8'h04
`define DPD_A_IDENT    8'h08
`define DPD_A_MSG      8'h0C
`define DPD_A_DIAG     8'h10
`define DPD_A_UDAT0    8'h14
`define DPD_A_UDAT1    8'h18
`define DPD_A_ISTAT    8'h1C
`define DPD_A_IMASK    8'h20
`define DPD_A_STATUS   8'h24

// ----------------------------------------------------------------------
// Fields and fixed values
// ----------------------------------------------------------------------
`define DPD_STN_WMASK  24'h80_3B5E
`define DPD_S1_FIX     8'h04
`define DPD_S0_FIXZ    8'hA1
`define DPD_EXT_BIT    3
`define DPD_DEV_LEN    8'h0A
`define DPD_DIAG_IGN   8'h03
`define DPD_DIAG_VAL   0
`define DPD_DIAG_DEL   1
`define DPD_MSG_RST    8'h40
`define DPD_MSG_PLEN   8'h12
`define DPD_MSG_CLEN   8'h13
`define DPD_MSG_CENT   8'h14
`define DPD_MSG_BUF    8'h15
`define DPD_MSG_NOCF   8'h16
`define DPD_MSG_CMP    8'h17
`define DPD_MSG_USER   8'h40
`define DPD_LAST_IDX   4'hF
`define DPD_IRQ_SENT   0
`define DPD_IRQ_REQ    1
`define DPD_IRQ_ERR    2

`endif

// *** inc/dpd_pkg.sv ***
/*
 * Types shared by the diagnostic frame builder modules.
 * Assumes compilation before the interface and the design modules.
 */
package dpd_pkg;
    typedef logic [7:0]   dpd_byte_t;
    typedef logic [127:0] dpd_frame_t;
    typedef enum logic [0:0] {
        DPD_IDLE = 1'b0,
        DPD_SEND = 1'b1
    } dpd_ser_e;
endpackage

// *** inc/dpd_frame_if.sv ***
/*
 * Carrier between the frame builder and its byte serialiser.
 * Assumes one source and one serialiser on the same clock.
 */
`timescale 1ns/1ps
interface dpd_frame_if;
    dpd_pkg::dpd_frame_t frame;
    logic                start;
    logic                busy;
    logic                done;
    modport src (output frame, output start, input busy, input done);
    modport ser (input frame, input start, output busy, output done);
endinterface

// *** rtl/dpd_trig.sv ***
/*
 * Watches the local diagnostic status byte and pulses start or delete.
 * Assumes the status byte is a register in the pclk domain.
 */
`timescale 1ns/1ps
`include "dpd_cfg.svh"
module dpd_trig (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Status byte in, events out
    input  wire logic [7:0] diag_st,
    output logic            start_p,
    output logic            del_p
);
    logic [7:0] prev_r;
    logic       ign;

    assign ign = (diag_st == `DPD_DIAG_IGN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r  <= 8'h00;
            start_p <= 1'b0;
            del_p   <= 1'b0;
        end else begin
            prev_r  <= diag_st;
            start_p <= !ign && !prev_r[`DPD_DIAG_VAL]
                       && diag_st[`DPD_DIAG_VAL];
            del_p   <= !ign && !prev_r[`DPD_DIAG_DEL]
                       && diag_st[`DPD_DIAG_DEL];
        end
    end

    property p_rise;
        @(posedge pclk) disable iff (!presetn)
        (!diag_st[`DPD_DIAG_VAL] ##1 (diag_st[`DPD_DIAG_VAL]
         && diag_st != `DPD_DIAG_IGN)) |=> start_p;
    endproperty
    a_rise: assert property (p_rise)
        else $error("rise of status bit 0 gave no start");

    property p_ign;
        @(posedge pclk) disable iff (!presetn)
        (diag_st == `DPD_DIAG_IGN) |=> !start_p && !del_p;
    endproperty
    a_ign: assert property (p_ign)
        else $error("status 0000 0011 was acted on");
endmodule

// *** rtl/dpd_ser.sv ***
/*
 * Sends a latched 16-byte frame, byte 0 first, with valid/ready.
 * Assumes the sink holds tx_ready as it likes; bytes wait for it.
 */
`timescale 1ns/1ps
`include "dpd_cfg.svh"
module dpd_ser (
    // Clock and reset
    input  wire logic      pclk,
    input  wire logic      presetn,
    // Frame from builder
    dpd_frame_if.ser       frm,
    // Byte stream to the bus side
    output dpd_pkg::dpd_byte_t tx_byte,
    output logic           tx_valid,
    output logic           tx_last,
    input  wire logic      tx_ready
);
    dpd_pkg::dpd_ser_e  state_r;
    dpd_pkg::dpd_frame_t sh_r;
    logic [3:0]          idx_r;
    logic                take;

    assign take     = tx_valid && tx_ready;
    assign frm.busy = (state_r == dpd_pkg::DPD_SEND);
    assign tx_byte  = sh_r[7:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r  <= dpd_pkg::DPD_IDLE;
            sh_r     <= '0;
            idx_r    <= 4'h0;
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
            frm.done <= 1'b0;
        end else begin
            frm.done <= 1'b0;
            case (state_r)
                dpd_pkg::DPD_IDLE: begin
                    if (frm.start) begin
                        // Snapshot so edits mid-frame cannot tear it
                        sh_r     <= frm.frame;
                        idx_r    <= 4'h0;
                        tx_valid <= 1'b1;
                        state_r  <= dpd_pkg::DPD_SEND;
                    end
                end
                default: begin
                    if (take) begin
                        sh_r  <= {8'h00, sh_r[127:8]};
                        idx_r <= idx_r + 4'h1;
                        // Flop, not decode: top outputs leave registers
                        tx_last <= (idx_r == `DPD_LAST_IDX - 4'h1);
                        if (idx_r == `DPD_LAST_IDX) begin
                            tx_valid <= 1'b0;
                            frm.done <= 1'b1;
                            state_r  <= dpd_pkg::DPD_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    property p_len;
        @(posedge pclk) disable iff (!presetn)
        (frm.start && !frm.busy) |=> tx_valid && idx_r == 4'h0;
    endproperty
    a_len: assert property (p_len)
        else $error("frame did not start at byte 0");
endmodule

// *** verification/dpd_master_model.sv ***
/*
 * Behavioural bus master that asks the slave for diagnostics and
 * collects the 16-byte answer, byte 0 first.
 * Assumes one clock; the bench steers request pulses and stalling.
 */
`timescale 1ns/1ps
module dpd_master_model (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Bench control
    input  wire logic         ask,
    input  wire logic         slow,
    // Request and byte stream
    output logic              diag_req,
    input  wire logic [7:0]   tx_byte,
    input  wire logic         tx_valid,
    input  wire logic         tx_last,
    output logic              tx_ready,
    // Collected frame
    output logic [127:0]      frame,
    output logic              done,
    output int                last_err
);
    logic [3:0] idx;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diag_req <= 1'b0;
            tx_ready <= 1'b0;
            frame    <= '0;
            done     <= 1'b0;
            idx      <= 4'h0;
            last_err <= 0;
        end else begin
            diag_req <= ask;
            // Random stalls show that bytes wait for the sink
            tx_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
            done     <= 1'b0;
            if (tx_valid && tx_ready) begin
                frame[8*idx +: 8] <= tx_byte;
                idx <= idx + 4'h1;
                if (tx_last != (idx == 4'hF)) begin
                    last_err <= last_err + 1;
                end
                if (tx_last) begin
                    idx  <= 4'h0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// *** verification/tb_top.sv ***
/*
 * Self-checking bench: APB driver, expected frames in a queue, and a
 * monitor that compares every collected frame with the oldest note.
 * Assumes the design and the master model share pclk.
 */
`timescale 1ns/1ps
module tb_top;
    logic         pclk, presetn, psel, penable, pwrite;
    logic [7:0]   paddr, tx_byte, err_code, maddr, msg;
    logic [31:0]  pwdata, prdata, stn, rd, ud0, ud1;
    logic         pready, pslverr, diag_req, err_evt, er;
    logic         tx_valid, tx_last, tx_ready, irq, ask, slow, done;
    logic [15:0]  ident;
    logic [127:0] frame;
    logic [127:0] exp_q[$];
    logic [7:0]   codes [8];
    int           last_err;
    int           mismatches;
    int           checks;

    dpd_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .diag_req(diag_req), .err_evt(err_evt),
        .err_code(err_code), .tx_byte(tx_byte), .tx_valid(tx_valid),
        .tx_last(tx_last), .tx_ready(tx_ready), .irq(irq));

    dpd_master_model u_mst (.pclk(pclk), .presetn(presetn), .ask(ask),
        .slow(slow), .diag_req(diag_req), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
        .frame(frame), .done(done), .last_err(last_err));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [127:0] mk(input logic uv);
        logic [127:0] f;
        f = '0;
        f[7:0]   = (stn[7:0] & 8'h5E) | {4'h0, uv, 3'h0};
        f[15:8]  = (stn[15:8] & 8'h3B) | 8'h04;
        f[23:16] = {stn[23], 7'h00};
        f[31:24] = maddr;
        f[47:32] = {ident[7:0], ident[15:8]};
        f[55:48] = 8'h0A;
        f[63:56] = msg;
        if (uv) f[127:88] = {ud1[7:0], ud0};
        return f;
    endfunction

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic ev(input logic a, input logic e, input logic [7:0] c);
        @(posedge pclk);
        ask      <= a;
        err_evt  <= e;
        err_code <= c;
        @(posedge pclk);
        ask     <= 1'b0;
        err_evt <= 1'b0;
    endtask

    task automatic drain;
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        if (exp_q.size() != 0) begin
            mismatches++;
            $display("[ERR] %0t frame missing", $time);
        end
        repeat (4) @(posedge pclk);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge pclk) begin
        if (presetn && done) begin
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("[ERR] %0t unexpected frame", $time);
            end else begin
                check(frame, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (30000) @(posedge pclk);
        mismatches++;
        summarize;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        {presetn, psel, penable, pwrite, ask, slow, err_evt} = '0;
        {paddr, pwdata, err_code} = '0;
        codes = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h40, 8'h55};
        void'($urandom(32'h8f93));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        msg = 8'h40;
        apb(0, 8'h00, 0);
        check(rd, 0);
        apb(0, 8'h0C, 0);
        check(rd, 32'h0000_0040);
        apb(0, 8'h28, 0);
        check({rd, er}, {32'h0000_0000, 1'b1});
        stn   = $urandom;
        maddr = 8'($urandom);
        ident = 16'($urandom);
        apb(1, 8'h00, stn);
        apb(1, 8'h04, {24'h00_0000, maddr});
        apb(1, 8'h08, {16'h0000, ident});
        apb(0, 8'h00, 0);
        check(rd, stn & 32'h0080_3B5E);
        exp_q.push_back(mk(0));
        ev(1, 0, 8'h00);
        drain;
        check(irq, 1'b0);
        apb(1, 8'h20, 1);
        repeat (2) @(posedge pclk);
        check(irq, 1'b1);
        apb(0, 8'h1C, 0);
        check(rd, 3);
        repeat (2) @(posedge pclk);
        check(irq, 1'b0);
        // Requests during a stalled frame merge into one more frame
        slow <= 1'b1;
        exp_q.push_back(mk(0));
        ev(1, 0, 8'h00);
        n = 0;
        while (tx_valid !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        msg = 8'h13;
        exp_q.push_back(mk(0));
        ev(1, 1, 8'h13);
        drain;
        apb(0, 8'h1C, 0);
        check(rd, 7);
        apb(0, 8'h1C, 0);
        check(rd, 0);
        foreach (codes[i]) begin
            if (codes[i] != 8'h55) msg = codes[i];
            exp_q.push_back(mk(0));
            ev(0, 1, codes[i]);
            drain;
        end
        apb(1, 8'h0C, 32'h0000_0033);
        apb(0, 8'h0C, 0);
        check(rd, {24'h00_0000, msg});
        ud0 = $urandom;
        ud1 = $urandom;
        msg = 8'h40;
        apb(1, 8'h0C, 32'h0000_0040);
        apb(1, 8'h14, ud0);
        apb(1, 8'h18, ud1);
        exp_q.push_back(mk(1));
        apb(1, 8'h10, 1);
        drain;
        apb(0, 8'h24, 0);
        check(rd[0], 1'b1);
        apb(1, 8'h10, 0);
        apb(1, 8'h10, 3);
        repeat (30) @(posedge pclk);
        apb(0, 8'h24, 0);
        check(rd[1:0], 2'b01);
        apb(1, 8'h10, 0);
        apb(1, 8'h10, 2);
        apb(0, 8'h24, 0);
        check(rd[0], 1'b0);
        exp_q.push_back(mk(0));
        ev(1, 0, 8'h00);
        drain;
        check(last_err, 0);
        summarize;
    end
endmodule
